// >>> verilog/sscp_pkg.sv
package sscp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timing figures
   localparam int CLK_NS     = 10;
   localparam int T_PU_US    = 450;  // Supply good to first access
   localparam int T_ZZEX_US  = 450;  // Sleep exit to first access
   localparam int T_ZZL_US   = 1;    // Least sleep pin low time
   localparam int T_RC_NS    = 110;  // Random read access
   localparam int T_AAP_NS   = 25;   // Page column access
   localparam int T_COL_NS   = 10;   // Column address stable
   localparam int T_CW_NS    = 55;   // Chip select low to write end
   localparam int T_PC_NS    = 55;   // Pre-charge
   localparam int SYNC_CYC   = 2;    // Data input synchroniser depth

   // Least times rounded up to whole cycles; read and page counts add SYNC_CYC
   localparam int PU_CYC   = (T_PU_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ZZEX_CYC = (T_ZZEX_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ZZL_CYC  = (T_ZZL_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC   = (T_RC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
   localparam int COL_CYC  = (T_COL_NS + CLK_NS - 1) / CLK_NS;
   localparam int PG_CYC   = (T_AAP_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
   localparam int WR_CYC   = (T_CW_NS + CLK_NS - 1) / CLK_NS;
   localparam int PC_CYC   = (T_PC_NS + CLK_NS - 1) / CLK_NS;
   localparam int LINGER_CYC = 8;    // Idle cycles before page ends

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ROW_W  = 16;
   localparam int COL_W  = 2;
   localparam int ADDR_W = ROW_W + COL_W;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 17;

   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_IDLE    = 4'h1,
      ST_READ    = 4'h2,
      ST_HOLD    = 4'h3,
      ST_PAGE    = 4'h4,
      ST_WRITE   = 4'h5,
      ST_WREND   = 4'h6,
      ST_PRECHG  = 4'h7,
      ST_SLEEP   = 4'h8,
      ST_WAKE    = 4'h9
   } sscp_state_t;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0]        be;      // Bit 1 upper lane, bit 0 lower lane
   } sscp_req_t;

   typedef struct packed {
      logic              chip_sel_n;
      logic              write_en_n;
      logic              out_en_n;
      logic              upper_lane_select_n;
      logic              lower_lane_select_n;
      logic              sleep_request_n;
      logic [ROW_W-1:0]  row_address_high;
      logic [COL_W-1:0]  column_address_low;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } sscp_pins_t;

   typedef struct packed {
      sscp_state_t       state;
      logic [CNT_W-1:0]  cnt;
      sscp_pins_t        pins;
      sscp_req_t         req;
      logic              pend;
      logic              ready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic              asleep;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
   } sscp_regs_t;

endpackage

// >>> verilog/sscp_host.sv
// Summary of operation
// - After reset the host waits 450 us before its first access.
// - After sleep rises the host waits 450 us before any access.
// - Sleep is entered only after the pre-charge that follows the last access.
// - In page mode the column address stays stable at least 10 ns.
// - A host with no byte writes may tie both lane selects low.
module sscp_host #(
   parameter int POWERUP_CYC = sscp_pkg::PU_CYC,
   parameter int WAKE_CYC    = sscp_pkg::ZZEX_CYC
) (
   input  wire logic                        sys_clk,
   input  wire logic                        srst,
   input  wire logic                        req_valid,
   input  wire sscp_pkg::sscp_req_t         req_in,
   output logic                             req_ready,
   output logic                             rd_valid,
   output logic [sscp_pkg::DATA_W-1:0]      rd_data,
   input  wire logic                        sleep_req,
   output logic                             asleep,
   output sscp_pkg::sscp_pins_t             mem_pins,
   input  wire logic [sscp_pkg::DATA_W-1:0] dq_in
);

   sscp_pkg::sscp_regs_t r_q;
   sscp_pkg::sscp_regs_t r_d;
   logic                 accept;

   ////////////////////////////////////////////////////////////////////////
   // Start an access from a held request
   function automatic sscp_pkg::sscp_regs_t launch(
      input sscp_pkg::sscp_regs_t r,
      input sscp_pkg::sscp_req_t  q
   );
      sscp_pkg::sscp_regs_t n;
      n                              = r;
      n.req                          = q;
      n.pend                         = 1'b0;
      n.ready                        = 1'b0;
      n.pins.chip_sel_n              = 1'b0;
      n.pins.row_address_high        = q.addr[sscp_pkg::ADDR_W-1:
                                              sscp_pkg::COL_W];
      n.pins.column_address_low      = q.addr[sscp_pkg::COL_W-1:0];
      n.pins.upper_lane_select_n     = ~q.be[1];
      n.pins.lower_lane_select_n     = ~q.be[0];
      if (q.write) begin
         // Select and write enable fall together: select-timed write
         n.pins.write_en_n = 1'b0;
         n.pins.out_en_n   = 1'b1;
         n.pins.dq_out     = q.wdata;
         n.pins.dq_oe      = 1'b1;
         n.state           = sscp_pkg::ST_WRITE;
         n.cnt             = sscp_pkg::CNT_W'(sscp_pkg::WR_CYC - 1);
      end else begin
         n.pins.write_en_n = 1'b1;
         n.pins.out_en_n   = 1'b0;
         n.pins.dq_oe      = 1'b0;
         n.state           = sscp_pkg::ST_READ;
         n.cnt             = sscp_pkg::CNT_W'(sscp_pkg::RD_CYC - 1);
      end
      return n;
   endfunction

   assign accept = req_valid && r_q.ready;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_d        = r_q;
      r_d.rvalid = 1'b0;
      r_d.sync1  = dq_in;       // First synchroniser stage
      r_d.sync2  = r_q.sync1;
      if (r_q.cnt != '0) begin
         r_d.cnt = r_q.cnt - 1'b1;
      end
      unique case (r_q.state)
         sscp_pkg::ST_POWERUP: begin
            if (r_q.cnt == '0) begin
               r_d.state = sscp_pkg::ST_IDLE;
               r_d.ready = 1'b1;
            end
         end
         sscp_pkg::ST_IDLE: begin
            if (accept) begin
               r_d = launch(r_d, req_in);
            end else if (sleep_req) begin
               // Select is already high and pre-charge done
               r_d.ready                = 1'b0;
               r_d.asleep               = 1'b1;
               r_d.pins.sleep_request_n = 1'b0;
               r_d.state                = sscp_pkg::ST_SLEEP;
               r_d.cnt = sscp_pkg::CNT_W'(sscp_pkg::ZZL_CYC - 1);
            end
         end
         sscp_pkg::ST_READ, sscp_pkg::ST_PAGE: begin
            if (r_q.cnt == '0) begin
               r_d.rdata  = r_q.sync2;
               r_d.rvalid = 1'b1;
               r_d.ready  = 1'b1;
               r_d.state  = sscp_pkg::ST_HOLD;
               r_d.cnt    = sscp_pkg::CNT_W'(sscp_pkg::LINGER_CYC - 1);
            end
         end
         sscp_pkg::ST_HOLD: begin
            if (accept && !req_in.write &&
                req_in.addr[sscp_pkg::ADDR_W-1:sscp_pkg::COL_W] ==
                r_q.pins.row_address_high) begin
               // Same row: column and lane selects change only, select stays low
               r_d.req                       = req_in;
               r_d.ready                     = 1'b0;
               r_d.pins.column_address_low   =
                  req_in.addr[sscp_pkg::COL_W-1:0];
               r_d.pins.upper_lane_select_n  = ~req_in.be[1];
               r_d.pins.lower_lane_select_n  = ~req_in.be[0];
               r_d.state                     = sscp_pkg::ST_PAGE;
               r_d.cnt = sscp_pkg::CNT_W'(sscp_pkg::PG_CYC - 1);
            end else if (accept || sleep_req || r_q.cnt == '0) begin
               // New row, write, sleep or linger end: pre-charge, then a full cycle if a request was taken
               r_d.req             = req_in;
               r_d.pend            = accept;
               r_d.ready           = 1'b0;
               r_d.pins.chip_sel_n = 1'b1;
               r_d.pins.out_en_n   = 1'b1;
               r_d.state           = sscp_pkg::ST_PRECHG;
               r_d.cnt = sscp_pkg::CNT_W'(sscp_pkg::PC_CYC - 1);
            end
         end
         sscp_pkg::ST_WRITE: begin
            if (r_q.cnt == '0) begin
               // Both edges rise together, data still driven
               r_d.pins.chip_sel_n = 1'b1;
               r_d.pins.write_en_n = 1'b1;
               r_d.state           = sscp_pkg::ST_WREND;
            end
         end
         sscp_pkg::ST_WREND: begin
            r_d.pins.dq_oe = 1'b0;
            r_d.state      = sscp_pkg::ST_PRECHG;
            r_d.cnt = sscp_pkg::CNT_W'(sscp_pkg::PC_CYC - 2);
         end
         sscp_pkg::ST_PRECHG: begin
            if (r_q.cnt == '0) begin
               if (r_q.pend) begin
                  r_d = launch(r_d, r_q.req);
               end else begin
                  r_d.state = sscp_pkg::ST_IDLE;
                  r_d.ready = 1'b1;
               end
            end
         end
         sscp_pkg::ST_SLEEP: begin
            if (r_q.cnt == '0 && !sleep_req) begin
               r_d.pins.sleep_request_n = 1'b1;
               r_d.state                = sscp_pkg::ST_WAKE;
               r_d.cnt = sscp_pkg::CNT_W'(WAKE_CYC - 1);
            end
         end
         sscp_pkg::ST_WAKE: begin
            if (r_q.cnt == '0) begin
               r_d.asleep = 1'b0;
               r_d.ready  = 1'b1;
               r_d.state  = sscp_pkg::ST_IDLE;
            end
         end
         default: begin
            r_d.state = sscp_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r_q                          <= '0;
         r_q.state                    <= sscp_pkg::ST_POWERUP;
         r_q.cnt <= sscp_pkg::CNT_W'(POWERUP_CYC - 1);
         r_q.pins.chip_sel_n          <= 1'b1;
         r_q.pins.write_en_n          <= 1'b1;
         r_q.pins.out_en_n            <= 1'b1;
         r_q.pins.upper_lane_select_n <= 1'b1;
         r_q.pins.lower_lane_select_n <= 1'b1;
         r_q.pins.sleep_request_n     <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign req_ready = r_q.ready;
   assign rd_valid  = r_q.rvalid;
   assign rd_data   = r_q.rdata;
   assign asleep    = r_q.asleep;
   assign mem_pins  = r_q.pins;

   ////////////////////////////////////////////////////////////////////////
   // Helper counters for checks
   int since_rst_q;
   int since_wake_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         since_rst_q  <= 0;
         since_wake_q <= WAKE_CYC;  // No wake owed after reset
      end else begin
         if (since_rst_q < POWERUP_CYC) begin
            since_rst_q <= since_rst_q + 1;
         end
         if (!r_q.pins.sleep_request_n) begin
            since_wake_q <= 0;
         end else if (since_wake_q < WAKE_CYC) begin
            since_wake_q <= since_wake_q + 1;
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   chk_powerup_wait: assert property (
      !mem_pins.chip_sel_n |-> since_rst_q >= POWERUP_CYC)
      else $error("access before power-up wait");
   chk_wake_wait: assert property (
      $fell(mem_pins.chip_sel_n) |-> since_wake_q >= WAKE_CYC)
      else $error("access before wake wait");
   chk_sleep_quiet: assert property (
      !mem_pins.sleep_request_n |-> mem_pins.chip_sel_n &&
      mem_pins.write_en_n && !mem_pins.dq_oe && asleep)
      else $error("pins active in sleep");
   chk_col_stable: assert property (
      ($changed(mem_pins.column_address_low) && !mem_pins.chip_sel_n)
      |=> $stable(mem_pins.column_address_low)[*3])
      else $error("column changed too soon");
   chk_lane_match: assert property (
      (!mem_pins.chip_sel_n && r_q.state != sscp_pkg::ST_HOLD) |->
      {mem_pins.upper_lane_select_n, mem_pins.lower_lane_select_n}
      == ~r_q.req.be)
      else $error("lane selects differ from request");
   chk_write_latch: assert property (
      $rose(mem_pins.write_en_n) |-> mem_pins.dq_oe &&
      $stable(mem_pins.dq_out) && $rose(mem_pins.chip_sel_n))
      else $error("write data not held at latch edge");
   chk_sleep_gap: assert property (
      $fell(mem_pins.sleep_request_n) |-> mem_pins.chip_sel_n ##1
      !mem_pins.sleep_request_n[*8])
      else $error("sleep pulse too short or select low");
   chk_read_data: assert property (
      rd_valid |-> !mem_pins.chip_sel_n && !mem_pins.out_en_n)
      else $error("read data returned without select");

endmodule

// >>> tb/sscp_mem_model.sv
module sscp_mem_model (
   pins,
   dq_bus,
   dq_drv,
   lane_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   input  wire sscp_pkg::sscp_pins_t pins;
   input  wire logic [15:0]          dq_bus;
   output logic [15:0]               dq_drv;
   output logic [1:0]                lane_oe;
   logic [15:0] mem [0:262143];
   logic [17:0] a_q;
   logic [15:0] d_q;
   logic [1:0]  ln_q;
   logic        wr_q = 1'b0;
   logic        sel;
   logic        rd_on;
   ////////////////////////////////////////////////////////////////////////
   // Sleep low masks all else; select high is standby
   assign sel = pins.sleep_request_n && !pins.chip_sel_n;
   assign rd_on = sel && pins.write_en_n && !pins.out_en_n;
   // Lanes driven only while read-selected, dropped at once in sleep
   assign lane_oe = {rd_on && !pins.upper_lane_select_n,
                     rd_on && !pins.lower_lane_select_n};
   // Any row change simply re-addresses the array
   assign dq_drv = mem[{pins.row_address_high,
                        pins.column_address_low}];
   ////////////////////////////////////////////////////////////////////////
   // Store on first rise of select or write enable, masked lanes kept
   always @(pins or dq_bus) begin
      if (wr_q && (pins.chip_sel_n || pins.write_en_n)) begin
         if (!ln_q[0]) mem[a_q][7:0] = d_q[7:0];
         if (!ln_q[1]) mem[a_q][15:8] = d_q[15:8];
      end
      wr_q = sel && !pins.write_en_n;
      if (wr_q) begin
         a_q = {pins.row_address_high, pins.column_address_low};
         d_q = dq_bus;
         ln_q = {pins.upper_lane_select_n, pins.lower_lane_select_n};
      end
   end
endmodule

// >>> tb/async_sram_port_sleep_control_bench.sv
module async_sram_port_sleep_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PWR  = 20;
   localparam int WAKE = 20;
   logic                 sys_clk;
   logic                 srst;
   logic                 req_valid;
   sscp_pkg::sscp_req_t  req_in;
   logic                 req_ready;
   logic                 rd_valid;
   logic [15:0]          rd_data;
   logic                 sleep_req;
   logic                 asleep;
   sscp_pkg::sscp_pins_t mem_pins;
   logic [15:0]          dq_in;
   logic [15:0]          dq_drv;
   logic [1:0]           lane_oe;
   logic [15:0]          last_q = 16'h0000;
   int                   bad_count = 0;
   int                   comparisons = 0;
   int                   cyc = 0;
   int                   hi_n = 0;
   int                   lat;

   sscp_host #(.POWERUP_CYC(PWR), .WAKE_CYC(WAKE)) sscp_host_inst (
      .sys_clk(sys_clk), .srst(srst), .req_valid(req_valid),
      .req_in(req_in), .req_ready(req_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .sleep_req(sleep_req), .asleep(asleep),
      .mem_pins(mem_pins), .dq_in(dq_in));
   sscp_mem_model sscp_mem_model_inst (
      .pins(mem_pins), .dq_bus(dq_in), .dq_drv(dq_drv),
      .lane_oe(lane_oe));

   ////////////////////////////////////////////////////////////////////////
   // Bus level per lane; a released lane shows its last level inverted
   function automatic logic [7:0] lvl(input logic h, input logic m,
      input logic [7:0] hd, input logic [7:0] md, input logic [7:0] l);
      return h ? hd : (m ? md : ~l);
   endfunction
   assign dq_in = {lvl(mem_pins.dq_oe, lane_oe[1], mem_pins.dq_out[15:8],
                       dq_drv[15:8], last_q[15:8]),
                   lvl(mem_pins.dq_oe, lane_oe[0], mem_pins.dq_out[7:0],
                       dq_drv[7:0], last_q[7:0])};

   // Clock, timeout, pre-charge gap watch
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      last_q <= dq_in;
      cyc <= cyc + 1;
      if (mem_pins.chip_sel_n) hi_n <= hi_n + 1;
      else begin
         chk(hi_n == 0 || hi_n >= 6, "pre-charge gap short");
         hi_n <= 0;
      end
      if (cyc == 5000) begin
         bad_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input bit ok, input string m);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_ready(output int n);
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      if (n >= 100) begin
         bad_count++;
         $display("CHECK FAILED at %0t: ready wait limit", $time);
      end
   endtask
   // One request: wait for ready, hold until taken, count to the answer
   task automatic xfer(input logic w, input logic [17:0] a,
      input logic [15:0] d, input logic [1:0] b, output int n);
      bit seen;
      seen = 1'b0;
      wait_ready(n);
      req_valid = 1'b1;
      req_in = '{w, a, d, b};
      tick();
      req_valid = 1'b0;
      n = 0;
      do begin
         tick();
         n++;
         // Lanes judged once select is low for this request
         if (!seen && mem_pins.chip_sel_n === 1'b0) begin
            seen = 1'b1;
            chk({mem_pins.upper_lane_select_n,
                 mem_pins.lower_lane_select_n} === ~b, "lanes");
         end
      end while (!(w ? req_ready === 1'b1 : rd_valid === 1'b1) && n < 60);
      chk(seen, "select never fell");
      if (n >= 60) begin
         bad_count++;
         $display("CHECK FAILED at %0t: answer wait limit", $time);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_powerup();
      wait_ready(lat);
      chk(lat >= PWR && lat <= PWR + 2, "power-up wait");
   endtask
   task automatic t_lanes();
      xfer(1'b1, 18'h01234, 16'h1234, 2'b11, lat);
      chk(lat == 12, "write length");
      xfer(1'b1, 18'h01234, 16'hab55, 2'b01, lat);
      xfer(1'b1, 18'h01234, 16'hcd66, 2'b10, lat);
      xfer(1'b0, 18'h01234, 16'h0000, 2'b11, lat);
      chk(lat == 13 && rd_data === 16'hcd55, "masked write");
      xfer(1'b0, 18'h01234, 16'h0000, 2'b01, lat);
      chk(rd_data[7:0] === 8'h55, "lower lane read");
   endtask
   task automatic t_page();
      xfer(1'b1, 18'h01235, 16'h5a5a, 2'b11, lat);
      xfer(1'b1, 18'h21234, 16'h0f0f, 2'b11, lat);
      xfer(1'b0, 18'h01234, 16'h0000, 2'b11, lat);
      chk(lat == 13 && rd_data === 16'hcd55, "random read");
      xfer(1'b0, 18'h01235, 16'h0000, 2'b11, lat);
      chk(lat == 5 && rd_data === 16'h5a5a, "page read");
      xfer(1'b0, 18'h21234, 16'h0000, 2'b11, lat);
      chk(lat >= 19 && lat <= 22, "row change latency");
      chk(rd_data === 16'h0f0f, "row change data");
   endtask
   task automatic t_sleep();
      int n;
      bit quiet;
      quiet = 1'b1;
      xfer(1'b1, 18'h00010, 16'hbeef, 2'b11, lat);
      sleep_req = 1'b1;
      n = 0;
      while (asleep !== 1'b1 && n < 30) begin
         tick();
         n++;
      end
      chk(n <= 2 && mem_pins.sleep_request_n === 1'b0, "entry");
      chk(lane_oe === 2'b00 && mem_pins.dq_oe === 1'b0, "bus free");
      repeat (120) begin
         tick();
         if (mem_pins.chip_sel_n !== 1'b1 || req_ready !== 1'b0)
            quiet = 1'b0;
      end
      chk(quiet, "activity in sleep");
      sleep_req = 1'b0;
      n = 0;
      while (asleep !== 1'b0 && n < 100) begin
         tick();
         n++;
      end
      chk(n >= WAKE && n <= WAKE + 2, "wake wait");
      xfer(1'b0, 18'h00010, 16'h0000, 2'b11, lat);
      chk(rd_data === 16'hbeef, "data over sleep");
   endtask

   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      srst = 1'b1;
      req_valid = 1'b0;
      req_in = '{1'b0, 18'h00000, 16'h0000, 2'b00};
      sleep_req = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      t_powerup();
      t_lanes();
      t_page();
      t_sleep();
      print_verdict();
   end
endmodule
